// ==== pkg/dwc_pkg.sv ====
package dwc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_DELAY_NS = 30_000_000;
  localparam int STEP_BASE0_NS = 25_600;
  localparam int STEP_BASE1_NS = 204_800;
  localparam int STEP_BASE2_NS = 1_638_400;
  localparam int STEP_12US_NS = 12_000;
  localparam int STEP_8US_NS = 8_000;
  localparam int STEP_4US_NS = 4_000;
  localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int STEP_BASE0_CYC = STEP_BASE0_NS / CLK_PERIOD_NS;
  localparam int STEP_BASE1_CYC = STEP_BASE1_NS / CLK_PERIOD_NS;
  localparam int STEP_BASE2_CYC = STEP_BASE2_NS / CLK_PERIOD_NS;
  localparam int STEP_12US_CYC = STEP_12US_NS / CLK_PERIOD_NS;
  localparam int STEP_8US_CYC = STEP_8US_NS / CLK_PERIOD_NS;
  localparam int STEP_4US_CYC = STEP_4US_NS / CLK_PERIOD_NS;
  // command codes and OPERATION data bytes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_UPPER = 8'h25;
  localparam logic [7:0] CMD_LOWER = 8'h26;
  localparam logic [7:0] CMD_STATUS = 8'hd0;
  localparam logic [7:0] CMD_CONFIG = 8'hd1;
  localparam logic [7:0] CMD_TRIGGER = 8'hd3;
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_MARGIN_LO = 8'h94;
  localparam logic [7:0] OP_MARGIN_HI = 8'ha4;
  // configuration, code, trigger and status word fields
  localparam int CFG_WSEL_LSB = 14;
  localparam int CFG_LOCK = 13;
  localparam int CFG_PMBUS_EN = 12;
  localparam int CFG_STEP_LSB = 9;
  localparam int CFG_INTV_LSB = 5;
  localparam int CFG_PDN_LSB = 3;
  localparam int CFG_REF_EN = 2;
  localparam int CODE_LSB = 4;
  localparam int TRG_RUN = 8;
  localparam int TRG_UNLOCK_LSB = 4;
  localparam int TRG_SRST_LSB = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_UNLOCKED = 1;
  localparam logic [3:0] SRST_KEY = 4'ha;
  localparam logic [3:0] UNLOCK_KEY = 4'h5;
  localparam logic [3:0] INTV_NONE = 4'hf;
  localparam logic [1:0] PDN_NORMAL = 2'h0;
  localparam logic [1:0] PDN_HIZ = 2'h2;
  localparam logic [15:0] CFG_RESET = 16'h01f0;
  localparam logic [15:0] CODE_RESET = 16'h0000;

  typedef enum logic [1:0] {DWC_ST_LOAD = 2'b00, DWC_ST_WAIT = 2'b01, DWC_ST_RUN = 2'b10} dwc_phase_e;
  typedef enum logic [1:0] {DWC_WV_TRI = 2'b00, DWC_WV_SAW_UP = 2'b01, DWC_WV_SAW_DN = 2'b10,
                            DWC_WV_SQUARE = 2'b11} dwc_wave_e;
  typedef struct packed {logic [15:0] cfg; logic [15:0] upper; logic [15:0] lower;} dwc_nvm_s;
  typedef struct packed {logic amp_pd; logic load_10k; logic hiz; logic ref_pd;} dwc_pwr_s;
  typedef struct packed {
    logic [3:0] bit_cnt; logic [1:0] idx; logic [7:0] shift; logic rd; logic addr_ok;
    logic sda_oe; logic [15:0] tx; logic rdy_s1; logic rdy_s2;
  } dwc_link_s;
  typedef struct packed {logic [7:0] ev_byte; logic [1:0] ev_idx; logic ev_tgl;} dwc_ev_s;
  typedef struct packed {
    dwc_phase_e phase; logic [20:0] por_cnt; logic [15:0] cfg; logic [15:0] upper;
    logic [15:0] lower; logic [7:0] cmd; logic [7:0] hi_byte; logic unlock; logic run;
    logic dir_up; logic [9:0] out_code; logic [17:0] tick_cnt; logic [15:0] rd_word;
    logic ev_s1; logic ev_s2; logic ev_s3; dwc_pwr_s pwr;
  } dwc_core_s;
endpackage : dwc_pkg

// ==== sim/dwc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dwc_host_model (
  input wire logic sda_oe_in,
  output logic clk_out,
  output logic frame_out,
  output logic sda_out
);
  logic drv_q;
  // open drain with pull-up: a released line reads high, not the last bit
  assign sda_out = drv_q & ~sda_oe_in;
  initial begin
    clk_out = 1'b0;
    frame_out = 1'b0;
    drv_q = 1'b1;
  end
  // the clock pulses only inside a frame and rests low between frames
  task automatic slot(input logic b, output logic oe, output logic ln);
    drv_q = b;
    #7.5 clk_out = 1'b1;
    #7.5 clk_out = 1'b0;
    oe = sda_oe_in;
    ln = sda_out;
  endtask : slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic oe, ln;
    for (int i = 7; i >= 0; i--) slot(b[i], oe, ln);
    ack = oe;
    slot(1'b1, oe, ln);
  endtask : put_byte
  task automatic frame(input logic on);
    #20 frame_out = on;
    #20;
  endtask : frame
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
                    input int nb, output logic [3:0] acks);
    frame(1'b1);
    put_byte({a, 1'b0}, acks[3]);
    put_byte(cmd, acks[2]);
    acks[1:0] = 2'b00;
    if (nb > 0) put_byte(d[15:8], acks[1]);
    if (nb > 1) put_byte(d[7:0], acks[0]);
    frame(1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] cmd, output logic [15:0] d);
    logic k, oe, ln;
    logic [7:0] ab;
    ab = {a, 1'b1};
    frame(1'b1);
    put_byte({a, 1'b0}, k);
    put_byte(cmd, k);
    frame(1'b0);
    #100; // frame ends after the command byte, then a fresh start
    frame(1'b1);
    for (int i = 7; i >= 0; i--) slot(ab[i], oe, ln);
    for (int j = 0; j < 18; j++) begin
      slot(j == 8 ? 1'b0 : 1'b1, oe, ln);
      if (j < 8) d[15 - j] = ln;
      else if (j > 8 && j < 17) d[16 - j] = ln;
    end
    frame(1'b0);
  endtask : rd
endmodule : dwc_host_model
`default_nettype wire

// ==== sim/dwc_waveform_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dwc_waveform_control_tb
  import dwc_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h48;
  logic ref_clk = 1'b0;
  logic sys_rst, lclk, lframe, lsda, sda_oe, ready, pend;
  logic [9:0] code;
  dwc_nvm_s nvm;
  dwc_pwr_s pwr;
  int errors = 0;
  int n_checks = 0;
  int seed = 49;
  always #12.5 ref_clk = ~ref_clk;
  dwc_waveform_control #(.DEV_ADDR(ADDR), .POR_CYC(20), .BASE1_CYC(16), .BASE2_CYC(32)) dut (
    .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .nvm_defaults_in(nvm),
    .link_clk_in(lclk), .link_frame_in(lframe), .link_sda_in(lsda), .link_sda_out(),
    .link_sda_oe_out(sda_oe), .out_code_out(code), .pwr_out(pwr), .ready_out(ready),
    .update_pending_out(pend));
  dwc_host_model host (.sda_oe_in(sda_oe), .clk_out(lclk), .frame_out(lframe), .sda_out(lsda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #2_000_000;
    errors++;
    end_sim();
  end
  function automatic dwc_pwr_s pwr_exp(input logic [15:0] c);
    logic [1:0] p;
    p = c[CFG_PDN_LSB +: 2];
    return dwc_pwr_s'{p != PDN_NORMAL, p[0], p == PDN_HIZ, !c[CFG_REF_EN]};
  endfunction : pwr_exp
  function automatic int nx(input logic [1:0] w, input int c, up, lo, st, inout int dir);
    if (w == 2'b11) return (c == up) ? lo : up;
    if (w == 2'b01) return (c == up) ? lo : ((c + st > up) ? up : c + st);
    if (w == 2'b10) return (c == lo) ? up : ((c - st < lo) ? lo : c - st);
    if (dir != 0) begin
      if (c + st >= up) dir = 0;
      return (c + st >= up) ? up : c + st;
    end
    if (c - st <= lo) dir = 1;
    return (c - st <= lo) ? lo : c - st;
  endfunction : nx
  task automatic wr2(input logic [7:0] cmd, input logic [15:0] d, input int nb);
    logic [3:0] ak;
    host.wr(ADDR, cmd, d, nb, ak);
    chk("ack", ak, nb > 1 ? 4'hf : 4'he);
    repeat (8) @(negedge ref_clk);
  endtask : wr2
  task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] v;
    host.rd(ADDR, cmd, v);
    chk(what, v, exp);
  endtask : rd_chk
  task automatic wait_rdy;
    for (int t = 0; t < 100 && ready !== 1'b1; t++) @(negedge ref_clk);
    chk("ready", ready, 1'b1);
  endtask : wait_rdy
  // steps are only timed after the first, whose start edge is not seen here
  task automatic wave(input logic [1:0] w, input int n);
    int up, lo, st, c, dir, t;
    logic [2:0] s;
    up = {$random(seed)} % 40 + 20;
    lo = up - {$random(seed)} % 6 - 2;
    s = 3'({$random(seed)} % 4);
    st = (s == 3'd2) ? 3 : 32'(s) + 1;
    wr2(CMD_UPPER, {4'h0, 8'(up), 4'h0}, 2);
    wr2(CMD_LOWER, {4'h0, 8'(lo), 4'h0}, 2);
    wr2(CMD_CONFIG, {w, 2'b01, s, 4'he, 2'b00, 1'b1, 2'b00}, 2);
    wr2(CMD_TRIGGER, 16'h0100, 2);
    up = up * 4;
    lo = lo * 4;
    dir = 1;
    c = (w == 2'b10) ? up : lo;
    chk("start", code, 10'(c));
    chk("pend", pend, 1'b1);
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (code === 10'(c) && t < 400) begin
        @(negedge ref_clk);
        t++;
      end
      if (i > 0) chk("intv", 16'(t), 16'(STEP_4US_CYC));
      c = nx(w, c, up, lo, st, dir);
      chk("code", code, 10'(c));
    end
    wr2(CMD_TRIGGER, 16'h0000, 2);
    chk("pend_off", pend, 1'b0);
  endtask : wave
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] ak;
    logic [15:0] dc, cf;
    sys_rst = 1'b1;
    dc = CFG_RESET;
    dc[4:2] = 3'($random(seed));
    nvm = '{dc, 16'h0120, 16'h0100};
    repeat (2) @(negedge ref_clk);
    chk("pwr_rst", pwr, 4'b1011);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    host.wr(ADDR, CMD_UPPER, 16'h0ff0, 2, ak);
    chk("ack_early", ak, 4'h0);
    wait_rdy();
    chk("pwr_nvm", pwr, pwr_exp(dc));
    rd_chk("cfg_nvm", CMD_CONFIG, dc);
    rd_chk("up_nvm", CMD_UPPER, 16'h0120);
    host.wr(ADDR ^ 7'h01, CMD_UPPER, 16'h0ff0, 2, ak);
    chk("ack_addr", ak, 4'h0);
    for (int p = 0; p < 4; p++) begin
      cf = {11'h00f, 2'(p), ~p[0], 2'b00};
      wr2(CMD_CONFIG, cf, 2);
      chk("pwr", pwr, pwr_exp(cf));
    end
    wr2(CMD_CONFIG, 16'h21f0, 2);
    wr2(CMD_UPPER, 16'h0330, 2);
    rd_chk("locked", CMD_UPPER, 16'h0120);
    wr2(CMD_TRIGGER, {8'h00, UNLOCK_KEY, 4'h0}, 2);
    rd_chk("status", CMD_STATUS, 16'h0002);
    wr2(CMD_UPPER, 16'h0330, 2);
    rd_chk("unlocked", CMD_UPPER, 16'h0330);
    wr2(CMD_OPERATION, {OP_MARGIN_HI, 8'h00}, 1);
    chk("op_off", code, 10'h000);
    wr2(CMD_CONFIG, 16'h11f0, 2);
    wr2(CMD_OPERATION, {OP_MARGIN_HI, 8'h00}, 1);
    chk("op_hi", code, 10'h0cc);
    wr2(CMD_OPERATION, {OP_MARGIN_LO, 8'h00}, 1);
    chk("op_lo", code, 10'h040);
    for (int w = 0; w < 4; w++) wave(2'(w), 10);
    wr2(CMD_TRIGGER, 16'h0009, 2);
    chk("no_srst", ready, 1'b1);
    wr2(CMD_TRIGGER, {12'h000, SRST_KEY}, 2);
    chk("srst", ready, 1'b0);
    wait_rdy();
    rd_chk("up_srst", CMD_UPPER, 16'h0120);
    end_sim();
  end
endmodule : dwc_waveform_control_tb
`default_nettype wire

// ==== src/dwc_waveform_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module dwc_waveform_control
  import dwc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h48,
  parameter int POR_CYC = POR_DELAY_CYC,
  parameter int BASE1_CYC = STEP_BASE1_CYC,
  parameter int BASE2_CYC = STEP_BASE2_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire dwc_nvm_s nvm_defaults_in,
  input wire logic link_clk_in,
  input wire logic link_frame_in,
  input wire logic link_sda_in,
  output logic link_sda_out,
  output logic link_sda_oe_out,
  output logic [9:0] out_code_out,
  output dwc_pwr_s pwr_out,
  output logic ready_out,
  output logic update_pending_out
);
  localparam logic [20:0] POR_LAST = 21'(POR_CYC - 1);

  if (POR_CYC < 1 || POR_CYC > 2_000_000 || BASE1_CYC < 1 || BASE2_CYC < 1
      || BASE2_CYC > 140_000) begin : g_bad_param
    $error("dwc_waveform_control: timing parameter out of range");
  end

  dwc_link_s lq, ld;
  dwc_ev_s eq, ed;
  dwc_core_s cq, cd;
  logic ev;
  logic [15:0] word;
  logic wr_ok;
  logic tick;
  logic [9:0] hi10, lo10, step;
  logic [10:0] up_sum, lo_lim;

  function automatic logic [17:0] intv_cyc(input logic [3:0] c);
    logic [17:0] b;
    b = (c[3:2] == 2'b00) ? 18'(STEP_BASE0_CYC) : (c[3:2] == 2'b01) ? 18'(BASE1_CYC) : 18'(BASE2_CYC);
    case (c)
      4'hc: intv_cyc = 18'(STEP_12US_CYC);
      4'hd: intv_cyc = 18'(STEP_8US_CYC);
      4'he: intv_cyc = 18'(STEP_4US_CYC);
      4'hf: intv_cyc = 18'(STEP_4US_CYC);
      default: intv_cyc = b + (c[0] ? (b >> 2) : 18'h0_0000) + (c[1] ? (b >> 1) : 18'h0_0000);
    endcase
  endfunction : intv_cyc

  function automatic logic [9:0] step_of(input logic [2:0] c);
    case (c)
      3'h4: step_of = 10'h006;
      3'h5: step_of = 10'h008;
      3'h6: step_of = 10'h010;
      3'h7: step_of = 10'h020;
      default: step_of = 10'(c) + 10'h001;
    endcase
  endfunction : step_of

  ////////////////////////////////////////////////////////////////////////////////
  // link side: runs on the host's bus clock; state is dropped when the frame ends
  always_comb begin
    logic [7:0] byte_in;
    ld = lq;
    ed = eq;
    byte_in = {lq.shift[6:0], link_sda_in};
    ld.rdy_s1 = (cq.phase == DWC_ST_RUN);
    ld.rdy_s2 = lq.rdy_s1;
    if (lq.bit_cnt < 4'h8) begin
      ld.shift = byte_in;
      ld.bit_cnt = lq.bit_cnt + 4'h1;
      if (lq.rd && lq.addr_ok && lq.bit_cnt < 4'h7) begin
        ld.sda_oe = ~lq.tx[15];
        ld.tx = {lq.tx[14:0], 1'b1};
      end
      if (lq.bit_cnt == 4'h7) begin
        ld.sda_oe = 1'b0;
        if (lq.idx == 2'h0) begin
          ld.addr_ok = (byte_in[7:1] == DEV_ADDR) && lq.rdy_s2;
          ld.rd = byte_in[0];
          ld.sda_oe = ld.addr_ok;
          ld.tx = cq.rd_word;
        end else if (!lq.rd && lq.addr_ok) begin
          ld.sda_oe = 1'b1;
          ed.ev_byte = byte_in;
          ed.ev_idx = lq.idx;
          ed.ev_tgl = ~eq.ev_tgl;
        end
      end
    end else begin
      ld.bit_cnt = 4'h0;
      if (lq.idx != 2'h3) ld.idx = lq.idx + 2'h1;
      ld.sda_oe = lq.rd && lq.addr_ok && !lq.tx[15];
      if (lq.rd && lq.addr_ok) ld.tx = {lq.tx[14:0], 1'b1};
    end
  end

  // frame low clears the byte machine even if the bus clock has stopped
  always_ff @(posedge link_clk_in or negedge link_frame_in) begin
    if (!link_frame_in) begin
      lq <= '{bit_cnt: 4'h0, idx: 2'h0, shift: 8'h00, rd: 1'b0, addr_ok: 1'b0, sda_oe: 1'b0,
              tx: 16'hffff, rdy_s1: 1'b0, rdy_s2: 1'b0};
    end else begin
      lq <= ld;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the last received byte must outlive the stop: the core picks it up a few
  // reference clocks later, by which time the frame may already be low
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      eq <= '{ev_byte: 8'h00, ev_idx: 2'h0, ev_tgl: 1'b0};
    end else begin
      eq <= ed;
    end
  end

  assign link_sda_out = 1'b0;
  assign link_sda_oe_out = lq.sda_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // core side
  assign ev = cq.ev_s2 ^ cq.ev_s3;
  assign word = {cq.hi_byte, eq.ev_byte};
  assign wr_ok = !cq.cfg[CFG_LOCK] || cq.unlock;
  assign hi10 = {cq.upper[CODE_LSB+7:CODE_LSB], 2'b00};
  assign lo10 = {cq.lower[CODE_LSB+7:CODE_LSB], 2'b00};
  assign step = step_of(cq.cfg[CFG_STEP_LSB+:3]);
  assign up_sum = {1'b0, cq.out_code} + {1'b0, step};
  assign lo_lim = {1'b0, lo10} + {1'b0, step};
  assign tick = cq.run && cq.cfg[CFG_INTV_LSB+:4] != INTV_NONE
                && cq.tick_cnt == intv_cyc(cq.cfg[CFG_INTV_LSB+:4]) - 18'h0_0001;

  always_comb begin
    cd = cq;
    // ev_tgl moves on the same bus clock edge that loads the byte and its index; ev fires two syncs later
    cd.ev_s1 = eq.ev_tgl;
    cd.ev_s2 = cq.ev_s1;
    cd.ev_s3 = cq.ev_s2;
    case (cq.phase)
      DWC_ST_LOAD: begin
        cd.cfg = nvm_defaults_in.cfg;
        cd.upper = nvm_defaults_in.upper;
        cd.lower = nvm_defaults_in.lower;
        cd.unlock = 1'b0;
        cd.run = 1'b0;
        cd.out_code = 10'h000;
        cd.por_cnt = 21'h0_0000;
        cd.phase = DWC_ST_WAIT;
      end
      DWC_ST_WAIT: begin
        cd.por_cnt = cq.por_cnt + 21'h0_0001;
        if (cq.por_cnt == POR_LAST) cd.phase = DWC_ST_RUN;
      end
      DWC_ST_RUN: begin
        cd.tick_cnt = (tick || !cq.run) ? 18'h0_0000 : cq.tick_cnt + 18'h0_0001;
        if (tick) begin
          case (dwc_wave_e'(cq.cfg[CFG_WSEL_LSB+:2]))
            DWC_WV_TRI: begin
              if (cq.dir_up) begin
                cd.out_code = (up_sum >= {1'b0, hi10}) ? hi10 : up_sum[9:0];
                cd.dir_up = !(up_sum >= {1'b0, hi10});
              end else begin
                cd.out_code = ({1'b0, cq.out_code} <= lo_lim) ? lo10 : cq.out_code - step;
                cd.dir_up = ({1'b0, cq.out_code} <= lo_lim);
              end
            end
            DWC_WV_SAW_UP: begin
              if (cq.out_code == hi10) cd.out_code = lo10;
              else cd.out_code = (up_sum >= {1'b0, hi10}) ? hi10 : up_sum[9:0];
            end
            DWC_WV_SAW_DN: begin
              if (cq.out_code == lo10) cd.out_code = hi10;
              else cd.out_code = ({1'b0, cq.out_code} <= lo_lim) ? lo10 : cq.out_code - step;
            end
            DWC_WV_SQUARE: cd.out_code = (cq.out_code == hi10) ? lo10 : hi10;
            default: cd.out_code = cq.out_code;
          endcase
        end
        if (ev) begin
          case (eq.ev_idx)
            2'h1: begin
              cd.cmd = eq.ev_byte;
              case (eq.ev_byte)
                CMD_CONFIG: cd.rd_word = cq.cfg;
                CMD_UPPER: cd.rd_word = cq.upper;
                CMD_LOWER: cd.rd_word = cq.lower;
                CMD_STATUS: cd.rd_word = 16'(cq.run) << STS_BUSY | 16'(cq.unlock) << STS_UNLOCKED;
                default: cd.rd_word = 16'h0000;
              endcase
            end
            2'h2: begin
              cd.hi_byte = eq.ev_byte;
              if (cq.cmd == CMD_OPERATION && cq.cfg[CFG_PMBUS_EN] && wr_ok) begin
                case (eq.ev_byte)
                  OP_OFF: cd.cfg[CFG_PDN_LSB+:2] = PDN_HIZ;
                  OP_ON: cd.cfg[CFG_PDN_LSB+:2] = PDN_NORMAL;
                  OP_MARGIN_LO: cd.out_code = lo10;
                  OP_MARGIN_HI: cd.out_code = hi10;
                  default: cd.cfg = cq.cfg;
                endcase
              end
            end
            2'h3: begin
              case (cq.cmd)
                CMD_CONFIG: if (wr_ok) cd.cfg = word;
                CMD_UPPER: if (wr_ok) cd.upper = word;
                CMD_LOWER: if (wr_ok) cd.lower = word;
                CMD_TRIGGER: begin
                  if (word[TRG_UNLOCK_LSB+:4] == UNLOCK_KEY) cd.unlock = 1'b1;
                  if (wr_ok) begin
                    cd.run = word[TRG_RUN];
                    cd.tick_cnt = 18'h0_0000;
                    cd.dir_up = 1'b1;
                    if (word[TRG_RUN])
                      cd.out_code = (cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SAW_DN) ? hi10 : lo10;
                  end
                  if (word[TRG_SRST_LSB+:4] == SRST_KEY) cd.phase = DWC_ST_LOAD;
                end
                default: cd.cmd = cq.cmd;
              endcase
            end
            default: cd.cmd = cq.cmd;
          endcase
        end
      end
      default: cd.phase = DWC_ST_LOAD;
    endcase
    cd.pwr.amp_pd = cd.cfg[CFG_PDN_LSB+:2] != PDN_NORMAL;
    cd.pwr.load_10k = cd.cfg[CFG_PDN_LSB];
    cd.pwr.hiz = cd.cfg[CFG_PDN_LSB+:2] == PDN_HIZ;
    cd.pwr.ref_pd = !cd.cfg[CFG_REF_EN];
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cq <= '{phase: DWC_ST_LOAD, por_cnt: 21'h0_0000, cfg: CFG_RESET, upper: CODE_RESET,
              lower: CODE_RESET, cmd: 8'h00, hi_byte: 8'h00, unlock: 1'b0, run: 1'b0,
              dir_up: 1'b1, out_code: 10'h000, tick_cnt: 18'h0_0000, rd_word: 16'h0000,
              ev_s1: 1'b0, ev_s2: 1'b0, ev_s3: 1'b0,
              pwr: '{amp_pd: 1'b1, load_10k: 1'b0, hiz: 1'b1, ref_pd: 1'b1}};
    end else begin
      cq <= cd;
    end
  end

  assign out_code_out = cq.out_code;
  assign pwr_out = cq.pwr;
  assign ready_out = cq.phase == DWC_ST_RUN;
  assign update_pending_out = cq.run;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_por_wait_done: assert property (cq.phase == DWC_ST_WAIT && cq.por_cnt == POR_LAST
    |=> ready_out) else $error("ready not raised after reset delay");
  a_por_no_early: assert property (cq.phase != DWC_ST_RUN |-> !ready_out && !(ev && cq.run))
    else $error("ready during reset delay");
  a_nvm_loaded: assert property (cq.phase == DWC_ST_LOAD |=> cq.cfg == $past(nvm_defaults_in.cfg)
    && cq.phase == DWC_ST_WAIT && !update_pending_out) else $error("defaults not loaded");
  a_soft_reset: assert property (ev && eq.ev_idx == 2'h3 && cq.cmd == CMD_TRIGGER
    && word[TRG_SRST_LSB+:4] == SRST_KEY && cq.phase == DWC_ST_RUN |=> cq.phase == DWC_ST_LOAD
    ##1 cq.phase == DWC_ST_WAIT) else $error("soft reset key ignored");
  a_lock_holds: assert property (ev && eq.ev_idx == 2'h3 && cq.cmd == CMD_UPPER && !wr_ok
    && cq.phase == DWC_ST_RUN |=> $stable(cq.upper)) else $error("locked write taken");
  a_unlock_key: assert property (ev && eq.ev_idx == 2'h3 && cq.cmd == CMD_TRIGGER
    && word[TRG_UNLOCK_LSB+:4] == UNLOCK_KEY && word[TRG_SRST_LSB+:4] != SRST_KEY
    && cq.phase == DWC_ST_RUN |=> wr_ok) else $error("unlock key ignored");
  a_pdn_decode: assert property (pwr_out.hiz == (cq.cfg[CFG_PDN_LSB+:2] == PDN_HIZ)
    && pwr_out.ref_pd == !cq.cfg[CFG_REF_EN]) else $error("power-down decode wrong");
  a_square_alt: assert property (tick && !ev && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SQUARE
    && cq.out_code == hi10 |=> out_code_out == $past(lo10)) else $error("square did not swap");
  a_no_step: assert property (cq.run && cq.cfg[CFG_INTV_LSB+:4] == INTV_NONE && !ev
    |=> $stable(out_code_out)) else $error("stepped with stepping off");
  a_tick_gap: assert property (tick && cq.cfg[CFG_INTV_LSB+:4] == 4'he |=> !tick [*8])
    else $error("steps too close");
  a_clamped: assert property (cq.run && lo10 <= hi10 && cq.out_code >= lo10 && cq.out_code <= hi10
    && tick && !ev |=> out_code_out >= lo10 && out_code_out <= hi10)
    else $error("code left its limits");
  a_link_ack: assert property (@(posedge link_clk_in) disable iff (!link_frame_in)
    lq.bit_cnt == 4'h7 && lq.idx == 2'h0 && {lq.shift[6:0], link_sda_in} == {DEV_ADDR, 1'b0}
    && lq.rdy_s2 |=> link_sda_oe_out ##1 !link_sda_oe_out) else $error("address not acked");

  a_saw_up_wrap: assert property (tick && !ev && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SAW_UP
    && cq.out_code == hi10 |=> out_code_out == $past(lo10))
    else $error("rising ramp did not restart");
  a_saw_dn_wrap: assert property (tick && !ev && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SAW_DN
    && cq.out_code == lo10 |=> out_code_out == $past(hi10))
    else $error("falling ramp did not restart");
  a_ramp_step: assert property (tick && !ev && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SAW_UP
    && cq.out_code != hi10 && up_sum < {1'b0, hi10}
    |=> out_code_out == $past(cq.out_code + step)) else $error("ramp step size wrong");
  a_tri_turn: assert property (tick && !ev && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_TRI
    && cq.dir_up && up_sum >= {1'b0, hi10}
    |=> out_code_out == $past(hi10) && !cq.dir_up) else $error("triangle did not turn");
  a_pmbus_gate: assert property (ev && eq.ev_idx == 2'h2 && cq.cmd == CMD_OPERATION
    && !cq.cfg[CFG_PMBUS_EN] && !tick && cq.phase == DWC_ST_RUN
    |=> $stable(cq.cfg) && $stable(out_code_out)) else $error("operation taken while off");

  c_saw_wrap: cover property (tick && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_SAW_DN
    && cq.out_code == lo10);
  c_lock_refuse: cover property (ev && eq.ev_idx == 2'h3 && !wr_ok);
  c_tri_turn: cover property (tick && cq.cfg[CFG_WSEL_LSB+:2] == DWC_WV_TRI && cq.dir_up
    ##1 !cq.dir_up);
  c_soft_reset: cover property (cq.phase == DWC_ST_RUN ##1 cq.phase == DWC_ST_LOAD);
  c_read_frame: cover property (@(posedge link_clk_in) lq.rd && lq.addr_ok && lq.idx == 2'h2);
endmodule : dwc_waveform_control
`default_nettype wire
